// >>> design/cmw_clock_ctrl.sv
// cpu clock mode selection, pll model, oscillator watchdog, axi4-lite regs
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cmw_clock_ctrl import cmw_pkg::*; #(
	parameter int PER_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] clock_mode_strap_pins,
	input wire logic clock_input_pin,
	output logic cpu_clk,
	output logic pll_enable,
	output logic clk_fail,
	output logic irq,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// strap, source and clocks
	logic [2:0] strap_r;
	cmw_src_e src_r, src_nxt;
	logic xin_r;
	logic [PER_W-1:0] per_cnt_r, per_cnt_nxt;
	logic [PER_W-1:0] period_r, period_nxt;
	logic [PER_W-1:0] acc_r, acc_nxt;
	logic cpu_clk_r, cpu_clk_nxt;
	logic pll_en_r, pll_en_nxt;
	logic clk_fail_r, clk_fail_nxt;
	logic [PER_W-1:0] free_cnt_r, free_cnt_nxt;
	logic free_clk_r, free_clk_nxt;
	logic [4:0] wdt_r, wdt_nxt;
	logic fail_evt;
	logic xin_edge, xin_rise, free_rise;
	logic [PER_W:0] acc_sum;
	// registers
	logic owd_dis_r, owd_dis_nxt;
	logic stat_r, stat_nxt;
	logic mask_r, mask_nxt;
	logic irq_r, irq_nxt;
	// axi
	logic [3:0] awaddr_r, awaddr_nxt;
	logic aw_held_r, aw_held_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic w_held_r, w_held_nxt;
	logic awready_r, awready_nxt;
	logic wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic arready_r, arready_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic do_write;
	logic wr_stat_clr;

	function automatic logic cmw_mapped(input logic [3:0] a);
		cmw_mapped = (a == REG_SYSCFG) || (a == REG_IRQ_STAT) ||
			(a == REG_IRQ_MASK) || (a == REG_MODE);
	endfunction : cmw_mapped

	assign xin_edge = clock_input_pin != xin_r;
	assign xin_rise = clock_input_pin && !xin_r;
	assign free_rise = free_clk_nxt && !free_clk_r;
	assign acc_sum = {1'b0, acc_r} +
		{{(PER_W-3){1'b0}}, cmw_factor2(strap_r)};

	// clock generation and watchdog
	always_comb begin
		src_nxt = src_r;
		per_cnt_nxt = per_cnt_r + 1'b1;
		period_nxt = period_r;
		acc_nxt = acc_r;
		cpu_clk_nxt = cpu_clk_r;
		free_cnt_nxt = free_cnt_r;
		free_clk_nxt = free_clk_r;
		wdt_nxt = wdt_r;
		fail_evt = 1'b0;
		if (xin_rise) begin
			// new period takes effect without clearing phase
			period_nxt = per_cnt_r + 1'b1;
			per_cnt_nxt = '0;
		end
		// free-running pll oscillator
		if (pll_en_r && src_r != SRC_PLL) begin
			if (free_cnt_r == PER_W'(FREE_HALF_CYC - 1)) begin
				free_cnt_nxt = '0;
				free_clk_nxt = !free_clk_r;
			end else begin
				free_cnt_nxt = free_cnt_r + 1'b1;
			end
		end else begin
			free_cnt_nxt = '0;
			free_clk_nxt = 1'b0;
		end
		case (src_r)
			SRC_PLL: begin
				// toggles 2F times per input period
				if (period_r != '0) begin
					if (acc_sum >= {1'b0, period_r}) begin
						acc_nxt = PER_W'(acc_sum - {1'b0, period_r});
						cpu_clk_nxt = !cpu_clk_r;
					end else begin
						acc_nxt = acc_sum[PER_W-1:0];
					end
				end
			end
			SRC_DIRECT: begin
				cpu_clk_nxt = clock_input_pin;
			end
			SRC_PRESC: begin
				if (xin_rise) begin
					cpu_clk_nxt = !cpu_clk_r;
				end
			end
			SRC_FAIL: begin
				cpu_clk_nxt = free_clk_r;
			end
			default: begin
				src_nxt = SRC_PLL;
			end
		endcase
		if ((src_r == SRC_DIRECT || src_r == SRC_PRESC) && !owd_dis_r) begin
			if (xin_edge) begin
				wdt_nxt = '0;
			end else if (free_rise) begin
				wdt_nxt = wdt_r + 1'b1;
			end
			if (wdt_r == WDT_OVF) begin
				fail_evt = 1'b1;
				src_nxt = SRC_FAIL;
				wdt_nxt = '0;
			end
		end else begin
			wdt_nxt = '0;
		end
		pll_en_nxt = (src_nxt == SRC_PLL) || (src_nxt == SRC_FAIL) ||
			!owd_dis_nxt;
		clk_fail_nxt = src_nxt == SRC_FAIL;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_r <= clock_mode_strap_pins;
			src_r <= cmw_decode(clock_mode_strap_pins);
			xin_r <= 1'b0;
			per_cnt_r <= '0;
			period_r <= '0;
			acc_r <= '0;
			cpu_clk_r <= 1'b0;
			pll_en_r <= 1'b1;
			clk_fail_r <= 1'b0;
			free_cnt_r <= '0;
			free_clk_r <= 1'b0;
			wdt_r <= '0;
		end else begin
			xin_r <= clock_input_pin;
			src_r <= src_nxt;
			per_cnt_r <= per_cnt_nxt;
			period_r <= period_nxt;
			acc_r <= acc_nxt;
			cpu_clk_r <= cpu_clk_nxt;
			pll_en_r <= pll_en_nxt;
			clk_fail_r <= clk_fail_nxt;
			free_cnt_r <= free_cnt_nxt;
			free_clk_r <= free_clk_nxt;
			wdt_r <= wdt_nxt;
		end
	end

	// axi4-lite slave
	assign do_write = aw_held_r && w_held_r && !bvalid_r;
	assign wr_stat_clr = do_write && awaddr_r == REG_IRQ_STAT &&
		wstrb_r[0] && wdata_r[IRQ_FAIL_BIT];

	always_comb begin
		awaddr_nxt = awaddr_r;
		aw_held_nxt = aw_held_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		w_held_nxt = w_held_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		arready_nxt = 1'b0;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		owd_dis_nxt = owd_dis_r;
		mask_nxt = mask_r;
		if (s_axi_awvalid && !aw_held_r) begin
			awaddr_nxt = s_axi_awaddr;
			aw_held_nxt = 1'b1;
		end
		if (s_axi_wvalid && !w_held_r) begin
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
			w_held_nxt = 1'b1;
		end
		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = cmw_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
			if (awaddr_r == REG_SYSCFG && wstrb_r[0]) begin
				owd_dis_nxt = wdata_r[OWD_DIS_BIT];
			end else if (awaddr_r == REG_IRQ_MASK && wstrb_r[0]) begin
				mask_nxt = wdata_r[IRQ_FAIL_BIT];
			end
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && !arready_r && !rvalid_r) begin
			arready_nxt = 1'b1;
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = '0;
			if (s_axi_araddr == REG_SYSCFG) begin
				rdata_nxt[OWD_DIS_BIT] = owd_dis_r;
			end else if (s_axi_araddr == REG_IRQ_STAT) begin
				rdata_nxt[IRQ_FAIL_BIT] = stat_r;
			end else if (s_axi_araddr == REG_IRQ_MASK) begin
				rdata_nxt[IRQ_FAIL_BIT] = mask_r;
			end else if (s_axi_araddr == REG_MODE) begin
				rdata_nxt[MODE_STRAP_LSB +: 3] = strap_r;
				rdata_nxt[MODE_SRC_LSB +: 2] = src_r;
				rdata_nxt[MODE_PLL_BIT] = pll_en_r;
				rdata_nxt[MODE_FAIL_BIT] = src_r == SRC_FAIL;
			end else begin
				rresp_nxt = RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		// set wins over write-one-to-clear
		stat_nxt = fail_evt ? 1'b1 : (wr_stat_clr ? 1'b0 : stat_r);
		irq_nxt = stat_nxt && mask_nxt;
		awready_nxt = !aw_held_nxt;
		wready_nxt = !w_held_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= '0;
			aw_held_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
			w_held_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
			owd_dis_r <= OWD_DIS_RST;
			stat_r <= 1'b0;
			mask_r <= IRQ_MASK_RST;
			irq_r <= 1'b0;
		end else begin
			awaddr_r <= awaddr_nxt;
			aw_held_r <= aw_held_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			w_held_r <= w_held_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			owd_dis_r <= owd_dis_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign cpu_clk = cpu_clk_r;
	assign pll_enable = pll_en_r;
	assign clk_fail = clk_fail_r;
	assign irq = irq_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule : cmw_clock_ctrl

// >>> inc/cmw_pkg.sv
// constants and types for the cpu clock mode and oscillator watchdog block
package cmw_pkg;
	// register byte offsets
	localparam logic [3:0] REG_SYSCFG = 4'h0;
	localparam logic [3:0] REG_IRQ_STAT = 4'h4;
	localparam logic [3:0] REG_IRQ_MASK = 4'h8;
	localparam logic [3:0] REG_MODE = 4'hc;
	// field positions
	localparam int OWD_DIS_BIT = 4;
	localparam int IRQ_FAIL_BIT = 0;
	localparam int MODE_STRAP_LSB = 0;
	localparam int MODE_SRC_LSB = 4;
	localparam int MODE_PLL_BIT = 8;
	localparam int MODE_FAIL_BIT = 9;
	// reset values
	localparam logic OWD_DIS_RST = 1'b0;
	localparam logic IRQ_MASK_RST = 1'b0;
	// strap codes with special meaning
	localparam logic [2:0] STRAP_DIRECT = 3'h3;
	localparam logic [2:0] STRAP_PRESC = 3'h1;
	// watchdog overflow count in free-running pll cycles
	localparam logic [4:0] WDT_OVF = 5'h10;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int FREE_PERIOD_NS = 200;
	localparam int FREE_HALF_CYC = FREE_PERIOD_NS / (2 * CLK_PERIOD_NS);
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// clock source state, gray coded
	typedef enum logic [1:0] {
		SRC_PLL = 2'h0,
		SRC_DIRECT = 2'h1,
		SRC_PRESC = 2'h3,
		SRC_FAIL = 2'h2
	} cmw_src_e;

	// twice the frequency factor, so 1.5 and 2.5 stay whole
	function automatic logic [3:0] cmw_factor2(input logic [2:0] code);
		case (code)
			3'h7: cmw_factor2 = 4'h8;
			3'h6: cmw_factor2 = 4'h6;
			3'h5: cmw_factor2 = 4'h4;
			3'h4: cmw_factor2 = 4'ha;
			3'h3: cmw_factor2 = 4'h2;
			3'h2: cmw_factor2 = 4'h3;
			3'h1: cmw_factor2 = 4'h1;
			default: cmw_factor2 = 4'h5;
		endcase
	endfunction : cmw_factor2

	function automatic cmw_src_e cmw_decode(input logic [2:0] code);
		if (code == STRAP_DIRECT) begin
			cmw_decode = SRC_DIRECT;
		end else if (code == STRAP_PRESC) begin
			cmw_decode = SRC_PRESC;
		end else begin
			cmw_decode = SRC_PLL;
		end
	endfunction : cmw_decode
endpackage : cmw_pkg

// >>> sim/cmw_osc_model.sv
// behavioural crystal or clock source on the block's clock input
`timescale 1ns/1ps
module cmw_osc_model (
	input wire logic aclk,
	input wire logic run,
	input wire logic [7:0] hi,
	input wire logic [7:0] lo,
	output logic clock_input_pin
);
	logic [7:0] cnt = 8'h00;
	initial clock_input_pin = 1'b0;
	// a stopped source holds its level, as a dead crystal does
	always @(posedge aclk) begin
		if (run) begin
			cnt <= cnt + 8'h01;
			if (cnt + 8'h01 >= (clock_input_pin ? hi : lo)) begin
				clock_input_pin <= !clock_input_pin;
				cnt <= 8'h00;
			end
		end
	end
endmodule : cmw_osc_model

// >>> sim/cmw_clock_ctrl_assertions.sv
// port checker for the clock mode and watchdog block
`timescale 1ns/1ps
module cmw_clock_ctrl_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pll_enable,
	input wire logic clk_fail,
	input wire logic irq,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar_once;
		s_axi_arready ##1 !s_axi_arready;
	endsequence
	a_fail_held: assert property (clk_fail |=> clk_fail)
		else $error("fail flag dropped");
	a_irq_cause: assert property (!clk_fail |-> !irq)
		else $error("irq without failure");
	a_fail_pll: assert property (clk_fail |-> pll_enable)
		else $error("failover without pll");
	a_pll_off: assert property (!pll_enable |-> !clk_fail)
		else $error("failure with pll off");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_ar_pulse: assert property (s_axi_arready |-> s_ar_once)
		else $error("arready longer than one cycle");
	a_aw_back: assert property ($rose(s_axi_bvalid)
		|-> s_axi_awready && s_axi_wready)
		else $error("address or data ready not back");
endmodule : cmw_clock_ctrl_chk

// >>> sim/test_cmw_clock_ctrl.sv
// self-checking testbench for the clock mode and watchdog block
`timescale 1ns/1ps
module test_cmw_clock_ctrl;
	import cmw_pkg::*;
	logic aclk = 0, aresetn = 0, clock_input_pin, run = 1;
	logic cpu_clk, pll_enable, clk_fail, irq;
	logic [7:0] hi = 8'h03, lo = 8'h05;
	logic [2:0] clock_mode_strap_pins = 3'h3;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int mismatches = 0, total_checks = 0, cyc = 0;
	cmw_clock_ctrl dut_u (.aclk, .aresetn, .clock_mode_strap_pins,
		.clock_input_pin, .cpu_clk, .pll_enable, .clk_fail, .irq,
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	cmw_osc_model osc_u (.aclk, .run, .hi, .lo, .clock_input_pin);
	always #2.5 aclk = !aclk;
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic chk(input logic c, input string m);
		total_checks++;
		if (c !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
			input logic [1:0] ex);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp === ex, "write response");
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] m,
			input logic [31:0] e, input logic [1:0] ex);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk((s_axi_rdata & m) === e && s_axi_rresp === ex, "read data");
		@(posedge aclk);
	endtask : rd
	task automatic rst(input logic [2:0] s);
		aresetn <= 1'b0;
		clock_mode_strap_pins <= s;
		repeat (8) @(posedge aclk);
		chk(!cpu_clk && pll_enable && !clk_fail && !irq, "reset");
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : rst
	task automatic tog(input int cy, input int e);
		int t;
		logic p;
		t = 0;
		p = cpu_clk;
		repeat (cy) begin
			@(posedge aclk);
			t += (cpu_clk !== p);
			p = cpu_clk;
		end
		chk(t >= e - 1 && t <= e + 1, "cpu clock rate");
	endtask : tog
	task automatic t_direct();
		int e;
		logic p;
		e = 0;
		rst(3'h3);
		rd(REG_MODE, 32'h3f7, 32'h113, RESP_OKAY);
		rd(REG_SYSCFG, 32'h10, 32'h0, RESP_OKAY);
		clock_mode_strap_pins <= 3'h0;
		wr(REG_MODE, 32'h0, RESP_OKAY);
		rd(REG_MODE, 32'h7, 32'h3, RESP_OKAY);
		rd(4'h2, 32'hffffffff, 32'h0, RESP_SLVERR);
		wr(4'h2, 32'h1, RESP_SLVERR);
		p = clock_input_pin;
		repeat (64) begin
			@(posedge aclk);
			if (cpu_clk !== p) e++;
			p = clock_input_pin;
		end
		chk(e == 0, "direct follow");
		wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
		rd(REG_IRQ_MASK, 32'h1, 32'h1, RESP_OKAY);
		run <= 1'b0;
		e = 0;
		while (clk_fail !== 1'b1 && e < 1000) begin
			@(posedge aclk);
			e++;
		end
		// first watchdog count may come up to one free-clock period after the last clear
		chk(e >= 30 * FREE_HALF_CYC - 8 && e <= 32 * FREE_HALF_CYC + 8,
			"fail timing");
		repeat (2) @(posedge aclk);
		chk(irq, "irq on fail");
		rd(REG_IRQ_STAT, 32'h1, 32'h1, RESP_OKAY);
		wr(REG_IRQ_MASK, 32'h0, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(!irq, "irq masked");
		wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
		run <= 1'b1;
		tog(200, 200 / FREE_HALF_CYC);
		chk(clk_fail && irq, "failover held");
		wr(REG_IRQ_STAT, 32'h1, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(!irq, "irq cleared");
	endtask : t_direct
	task automatic t_presc();
		rst(3'h1);
		tog(80, 10);
		chk(pll_enable, "pll free runs");
		wr(REG_SYSCFG, 32'h10, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(!pll_enable, "pll off");
		run <= 1'b0;
		repeat (800) @(posedge aclk);
		chk(!clk_fail, "no watchdog");
		run <= 1'b1;
	endtask : t_presc
	task automatic t_pll();
		int cd[6] = '{7, 6, 5, 4, 2, 0};
		int f2[6] = '{8, 6, 4, 10, 3, 5};
		hi <= 8'd60;
		lo <= 8'd60;
		for (int i = 0; i < 6; i++) begin
			rst(cd[i][2:0]);
			repeat (400) @(posedge aclk);
			tog(480, 4 * f2[i]);
			chk(pll_enable, "pll enabled");
		end
	endtask : t_pll
	initial begin
		t_direct();
		t_presc();
		t_pll();
		final_report();
	end
endmodule : test_cmw_clock_ctrl
bind cmw_clock_ctrl cmw_clock_ctrl_chk chk_u (.aclk, .aresetn,
	.pll_enable, .clk_fail, .irq, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
